/* File: scd_pkg.sv */
// shared constants and types for the adc measurement configuration block
package scd_pkg;

   // ********************************************************
   // register indices (byte address is four times the index)
   // ********************************************************
   localparam logic [5:0] PROX_GAIN_IDX = 6'h0b;
   localparam logic [5:0] PROX_MISC_IDX = 6'h0c;
   localparam logic [5:0] IR_SEL_IDX = 6'h0e;
   localparam logic [5:0] AUX_SEL_IDX = 6'h0f;
   localparam logic [5:0] VIS_REC_IDX = 6'h10;
   localparam logic [5:0] VIS_GAIN_IDX = 6'h11;
   localparam logic [5:0] CTRL_IDX = 6'h18;
   localparam logic [5:0] STAT_IDX = 6'h19;

   // ********************************************************
   // reset values
   // ********************************************************
   localparam logic [7:0] PROX_GAIN_RST = 8'h00;
   localparam logic [7:0] PROX_MISC_RST = 8'h04;
   localparam logic [7:0] IR_SEL_RST = 8'h00;
   localparam logic [7:0] AUX_SEL_RST = 8'h65;
   localparam logic [7:0] VIS_REC_RST = 8'h70;
   localparam logic [7:0] VIS_GAIN_RST = 8'h00;

   // ********************************************************
   // field positions
   // ********************************************************
   localparam int GAIN_LSB = 0;
   localparam int GAIN_W = 3;
   localparam int RANGE_BIT = 5;
   localparam int MODE_BIT = 2;
   localparam int REC_LSB = 4;
   localparam int REC_W = 3;
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_KIND_LSB = 1;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_KIND_LSB = 1;
   localparam int STAT_DONE_BIT = 3;

   // input codes for the two documented mux selections
   localparam logic [7:0] IR_SMALL_PD = 8'h00;
   localparam logic [7:0] IR_LARGE_PD = 8'h03;
   localparam logic [7:0] AUX_TEMP = 8'h65;
   localparam logic [7:0] AUX_SUPPLY = 8'h75;

   // ********************************************************
   // timing
   // ********************************************************
   localparam int CLK_PERIOD_NS = 25;
   localparam int ADC_PERIOD_NS = 50;
   localparam int ADC_BASE_CYCLES =
      (ADC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 10;

   // ********************************************************
   // types
   // ********************************************************
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RECOVER = 2'b01,
      ST_INTEGRATE = 2'b11,
      ST_DONE = 2'b10
   } scd_state_type;

   typedef enum logic [1:0] {
      K_PROX = 2'b00,
      K_VIS = 2'b01,
      K_IR = 2'b10,
      K_AUX = 2'b11
   } scd_kind_type;

endpackage

/* File: scd_tick_div.sv */
// adc clock tick generator divided by two to the gain exponent
module scd_tick_div
   import scd_pkg::*;
#(
   parameter int BASE = ADC_BASE_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic run_i,
   input wire logic [2:0] exp_i,
   output logic tick_o
);

   // ********************************************************
   // divider
   // ********************************************************
   // widest period is base times 128 clocks, that is 128 adc clocks
   localparam int DW = $clog2(BASE * 128) + 1;

   logic [DW-1:0] cnt_q;
   logic [DW-1:0] limit;

   // exponent zero leaves the adc clock undivided
   assign limit = DW'(BASE) << exp_i;

   // counter restarts whenever the sequencer is not running a phase
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q <= '0;
         tick_o <= 1'b0;
      end else if (ce_i) begin
         if (!run_i) begin
            cnt_q <= '0;
            tick_o <= 1'b0;
         end else if (cnt_q == limit - DW'(1)) begin
            cnt_q <= '0;
            tick_o <= 1'b1;
         end else begin
            cnt_q <= cnt_q + DW'(1);
            tick_o <= 1'b0;
         end
      end
   end

endmodule

/* File: scd_measure_cfg.sv */
// measurement configuration registers and adc measurement sequencer
//
// What this block does
// - proximity gain exponent stretches emitter and integration by 2^exp
// - exponent zero leaves adc clock undivided; each step doubles the divide
// - misc bit 5 selects proximity high signal range, gain cut by 14.5
// - misc bit 2: zero raw adc mode, one normal proximity (reset)
// - ambient ir select 0x00 small photodiode, 0x03 large photodiode
// - aux select: 0x65 relative temperature, 0x75 supply, both to ground
// - visible recovery waits 1..511 adc clocks per code, times 2^vis gain
// - on early silicon visible recovery also governs ambient ir recovery
// - visible gain stretches visible integration and recovery by 2^exp
//
// Decided for this implementation: register access over Wishbone.
module scd_measure_cfg
   import scd_pkg::*;
#(
   parameter int INTEG_TICKS = 16,
   parameter int EMIT_TICKS = 8,
   parameter logic [7:0] PROX_MUX = 8'h03,
   parameter logic [7:0] VIS_MUX = 8'h02,
   parameter bit EARLY_REV = 1'b0
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   output logic [7:0] adc_sel_o,
   output logic integrate_o,
   output logic emitter_o,
   output logic high_range_o,
   output logic raw_mode_o,
   output logic busy_o,
   output logic done_o
);

   // ********************************************************
   // stored settings
   // ********************************************************
   // defined fields only, reserved bits are never stored
   logic [2:0] prox_gain_exponent_q;
   logic proximity_high_range_q;
   logic proximity_measure_mode_q;
   logic [7:0] ambient_ir_input_select_q;
   logic [7:0] auxiliary_input_select_q;
   logic [2:0] visible_recovery_code_q;
   logic [2:0] visible_gain_exponent_q;

   // ********************************************************
   // bus decode
   // ********************************************************
   logic req;
   logic wr;
   logic [5:0] idx;
   logic [7:0] wbyte;
   logic start_req;
   scd_kind_type start_kind;

   // ack blocks a second take while the master still holds its strobe
   assign req = cyc_i && stb_i && !ack_o;
   assign wr = req && we_i && sel_i[0];
   assign idx = adr_i[7:2];
   assign wbyte = dat_i[7:0];

   // ********************************************************
   // sequencer state
   // ********************************************************
   // state, phase counter and the settings snapshot of the running phase
   scd_state_type state_q;
   scd_kind_type kind_q;
   logic done_seen_q;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] rec_len_q;
   logic [2:0] div_exp_q;
   logic tick;
   logic run;
   logic rec_last;

   assign start_req = wr && (idx == CTRL_IDX) && dat_i[CTRL_START_BIT];
   assign start_kind = scd_kind_type'(dat_i[CTRL_KIND_LSB +: 2]);

   // last divided tick of the recovery phase
   assign rec_last = tick && (cnt_q == rec_len_q - CNT_W'(1));

   // the divider is let go for one cycle on the way from recovery into
   // integration; both entry paths then see the same first-tick delay,
   // so the integrate window keeps its full length after a recovery
   assign run = ((state_q == ST_RECOVER) && !rec_last) ||
      (state_q == ST_INTEGRATE);

   // ********************************************************
   // register writes
   // ********************************************************
   // only defined fields are kept, so reserved bits read back as zero
   // a write with byte lane zero off is dropped: every setting is a byte
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prox_gain_exponent_q <= PROX_GAIN_RST[GAIN_LSB +: GAIN_W];
         proximity_high_range_q <= PROX_MISC_RST[RANGE_BIT];
         proximity_measure_mode_q <= PROX_MISC_RST[MODE_BIT];
         ambient_ir_input_select_q <= IR_SEL_RST;
         auxiliary_input_select_q <= AUX_SEL_RST;
         visible_recovery_code_q <= VIS_REC_RST[REC_LSB +: REC_W];
         visible_gain_exponent_q <= VIS_GAIN_RST[GAIN_LSB +: GAIN_W];
      end else if (ce_i && wr) begin
         unique case (idx)
            // exponent taken as written, above five is the host's risk
            PROX_GAIN_IDX: begin
               prox_gain_exponent_q <= wbyte[GAIN_LSB +: GAIN_W];
            end
            PROX_MISC_IDX: begin
               proximity_high_range_q <= wbyte[RANGE_BIT];
               proximity_measure_mode_q <= wbyte[MODE_BIT];
            end
            IR_SEL_IDX: begin
               ambient_ir_input_select_q <= wbyte;
            end
            AUX_SEL_IDX: begin
               auxiliary_input_select_q <= wbyte;
            end
            VIS_REC_IDX: begin
               // low nibble is reserved and dropped
               visible_recovery_code_q <= wbyte[REC_LSB +: REC_W];
            end
            VIS_GAIN_IDX: begin
               visible_gain_exponent_q <= wbyte[GAIN_LSB +: GAIN_W];
            end
            default: begin
            end
         endcase
      end
   end

   // ********************************************************
   // bus answer
   // ********************************************************
   // one wait state for every access; unmapped reads return zero
   // the control index is write-only and reads back as zero
   // status is sampled as the read is taken, one cycle before ack
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else if (ce_i) begin
         ack_o <= req;
         dat_o <= 32'h0000_0000;
         if (req && !we_i) begin
            unique case (idx)
               PROX_GAIN_IDX: dat_o[GAIN_LSB +: GAIN_W] <=
                  prox_gain_exponent_q;
               PROX_MISC_IDX: begin
                  dat_o[RANGE_BIT] <= proximity_high_range_q;
                  dat_o[MODE_BIT] <= proximity_measure_mode_q;
               end
               IR_SEL_IDX: dat_o[7:0] <= ambient_ir_input_select_q;
               AUX_SEL_IDX: dat_o[7:0] <= auxiliary_input_select_q;
               VIS_REC_IDX: dat_o[REC_LSB +: REC_W] <=
                  visible_recovery_code_q;
               VIS_GAIN_IDX: dat_o[GAIN_LSB +: GAIN_W] <=
                  visible_gain_exponent_q;
               STAT_IDX: begin
                  dat_o[STAT_BUSY_BIT] <= busy_o;
                  dat_o[STAT_KIND_LSB +: 2] <= kind_q;
                  dat_o[STAT_DONE_BIT] <= done_seen_q;
               end
               default: begin
               end
            endcase
         end
      end
   end

   // ********************************************************
   // adc tick divider
   // ********************************************************
   // the divider only counts while a phase runs, so an idle block
   // toggles nothing but the bus logic; the cost is a one-cycle
   // start-up delay before the first divided tick
   scd_tick_div #(
      .BASE(ADC_BASE_CYCLES)
   ) u_div (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .run_i(run),
      .exp_i(div_exp_q),
      .tick_o(tick)
   );

   // recovery length in adc clocks: 1, 7, 15 ... 511
   // code zero is a single clock, any other code is 2^(code+2)-1
   // the counter is wide enough for the longest code
   function automatic logic [CNT_W-1:0] rec_len(input logic [2:0] code);
      logic [CNT_W-1:0] r;
      r = (CNT_W'(1) << (CNT_W'(code) + CNT_W'(2))) - CNT_W'(1);
      return (code == 3'd0) ? CNT_W'(1) : r;
   endfunction

   // ********************************************************
   // measurement sequencer
   // ********************************************************
   // settings are sampled once at start, so mid-measurement writes
   // only affect the next run
   // a start that lands while busy is dropped without notice, so the
   // host watches busy or the status word before the next one
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= ST_IDLE;
         kind_q <= K_PROX;
         cnt_q <= '0;
         rec_len_q <= '0;
         div_exp_q <= 3'd0;
         adc_sel_o <= 8'h00;
         high_range_o <= 1'b0;
         raw_mode_o <= 1'b0;
      end else if (ce_i) begin
         unique case (state_q)
            ST_IDLE: begin
               cnt_q <= '0;
               if (start_req) begin
                  kind_q <= start_kind;
                  high_range_o <= 1'b0;
                  raw_mode_o <= 1'b0;
                  rec_len_q <= rec_len(visible_recovery_code_q);
                  state_q <= ST_INTEGRATE;
                  unique case (start_kind)
                     K_PROX: begin
                        // six and seven pass unclamped, see the host limit
                        div_exp_q <= prox_gain_exponent_q;
                        adc_sel_o <= PROX_MUX;
                        high_range_o <= proximity_high_range_q;
                        raw_mode_o <= !proximity_measure_mode_q;
                     end
                     K_VIS: begin
                        // recovery and integration share the visible gain
                        div_exp_q <= visible_gain_exponent_q;
                        adc_sel_o <= VIS_MUX;
                        state_q <= ST_RECOVER;
                     end
                     K_IR: begin
                        // older parts share the visible timing settings
                        div_exp_q <= EARLY_REV ?
                           visible_gain_exponent_q : 3'd0;
                        adc_sel_o <= ambient_ir_input_select_q;
                        if (EARLY_REV) begin
                           state_q <= ST_RECOVER;
                        end
                     end
                     K_AUX: begin
                        // auxiliary readings use the undivided adc clock
                        div_exp_q <= 3'd0;
                        adc_sel_o <= auxiliary_input_select_q;
                     end
                  endcase
               end
            end
            ST_RECOVER: begin
               if (tick) begin
                  if (cnt_q == rec_len_q - CNT_W'(1)) begin
                     cnt_q <= '0;
                     state_q <= ST_INTEGRATE;
                  end else begin
                     cnt_q <= cnt_q + CNT_W'(1);
                  end
               end
            end
            ST_INTEGRATE: begin
               // integration length counts divided ticks
               if (tick) begin
                  if (cnt_q == CNT_W'(INTEG_TICKS - 1)) begin
                     cnt_q <= '0;
                     state_q <= ST_DONE;
                  end else begin
                     cnt_q <= cnt_q + CNT_W'(1);
                  end
               end
            end
            ST_DONE: begin
               // one settle cycle so done and status line up
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // ********************************************************
   // front-end strobes
   // ********************************************************
   // integrate window rises one cycle behind the state machine and falls with it,
   // so it opens at least one cycle after the registered mux code settles
   // integrate rises one cycle after the phase begins, which the
   // start-up cycle of the divider makes up for
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         integrate_o <= 1'b0;
         busy_o <= 1'b0;
         done_o <= 1'b0;
      end else if (ce_i) begin
         integrate_o <= (state_q == ST_INTEGRATE) &&
            !(tick && cnt_q == CNT_W'(INTEG_TICKS - 1));
         busy_o <= (state_q != ST_IDLE) || start_req;
         done_o <= (state_q == ST_INTEGRATE) && tick &&
            (cnt_q == CNT_W'(INTEG_TICKS - 1));
      end
   end

   // emitter only fires on normal proximity, never in raw adc mode;
   // its width is counted in divided ticks so the gain stretches it
   // a pulse longer than the integration is cut one cycle after integrate falls
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         emitter_o <= 1'b0;
      end else if (ce_i) begin
         emitter_o <= (state_q == ST_INTEGRATE) && (kind_q == K_PROX) &&
            !raw_mode_o && (cnt_q < CNT_W'(EMIT_TICKS)) &&
            !(tick && cnt_q == CNT_W'(EMIT_TICKS - 1));
      end
   end

   // done flag: set by the finishing measurement, cleared by a new start;
   // the set wins when both meet
   // status keeps the flag until the host starts again
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         done_seen_q <= 1'b0;
      end else if (ce_i) begin
         if (state_q == ST_DONE) begin
            done_seen_q <= 1'b1;
         end else if (start_req && state_q == ST_IDLE) begin
            done_seen_q <= 1'b0;
         end
      end
   end

endmodule

/* File: scd_measure_cfg_checker.sv */
// port assertions for the measurement configuration block
module scd_measure_cfg_checker (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic ack_o,
   input wire logic [7:0] adc_sel_o,
   input wire logic integrate_o,
   input wire logic emitter_o,
   input wire logic high_range_o,
   input wire logic raw_mode_o,
   input wire logic busy_o,
   input wire logic done_o
);
   // ********************************************************
   // properties
   // ********************************************************
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // settings seen by the adc, may change only at a start
   logic [9:0] set_w;
   assign set_w = {adc_sel_o, high_range_o, raw_mode_o};
   // a request that has not been answered yet
   sequence s_req;
      ce_i && cyc_i && stb_i && !ack_o;
   endsequence
   // small slack on the tail, the exact count is not a rule
   sequence s_wind_down;
      busy_o ##[1:3] !busy_o;
   endsequence
   AST_REQ_ACK: assert property (s_req |=> ack_o)
      else $error("request not answered next cycle");
   AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   AST_BUSY_ACK: assert property ($rose(busy_o) |-> ack_o)
      else $error("sequencer started without a bus write");
   AST_DONE_END: assert property (done_o |-> s_wind_down)
      else $error("busy did not fall after done");
   AST_DONE_PULSE: assert property (done_o |=> !done_o)
      else $error("done longer than one cycle");
   AST_SET_HOLD: assert property (!$rose(busy_o) |-> $stable(set_w))
      else $error("settings changed outside a start");
   AST_IDLE_QUIET: assert property (!busy_o |-> !integrate_o)
      else $error("integration while idle");
   AST_EMIT_NORMAL: assert property (emitter_o |-> !raw_mode_o)
      else $error("emitter pulse in raw mode");
endmodule

bind scd_measure_cfg scd_measure_cfg_checker u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i),
   .stb_i(stb_i), .ack_o(ack_o), .adc_sel_o(adc_sel_o),
   .integrate_o(integrate_o), .emitter_o(emitter_o),
   .high_range_o(high_range_o), .raw_mode_o(raw_mode_o),
   .busy_o(busy_o), .done_o(done_o)
);

/* File: scd_host_model.sv */
// wishbone host that configures and starts the measurement block
module scd_host_model (
   input wire logic clk_i,
   input wire logic ack_i,
   input wire logic [31:0] dat_i,
   output logic cyc_o,
   output logic stb_o,
   output logic we_o,
   output logic [7:0] adr_o,
   output logic [3:0] sel_o,
   output logic [31:0] dat_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // bus idle from time zero
   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o = 1'b0;
      adr_o = 8'h00;
      sel_o = 4'h0;
      dat_o = 32'h0000_0000;
   end
   // one classic cycle, held until ack is sampled high
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [7:0] d, input logic [3:0] s, output logic [7:0] q);
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o <= w;
      adr_o <= a;
      sel_o <= s;
      dat_o <= {24'h00_0000, d};
      do @(posedge clk_i); while (ack_i !== 1'b1);
      q = dat_i[7:0];
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
      input logic [3:0] s);
      logic [7:0] q;
      xfer(1'b1, a, d, s, q);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      xfer(1'b0, a, 8'h00, 4'hf, q);
   endtask
endmodule

/* File: tb.sv */
// self-checking bench for the measurement configuration block
module tb
   import scd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int IT = 4;
   localparam int ET = 2;
   localparam logic [7:0] PM = 8'h5a;
   localparam logic [7:0] VM = 8'h3c;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc, stb, we, ack, integ_w, emit_w, hr_w, raw_w, busy_w, done_w;
   logic [7:0] adr, sel_w;
   logic [3:0] bsel;
   logic [31:0] wdat, rdat;
   int n_fail = 0;
   int checks = 0;
   int tick_n = 0;
   int dprox;
   scd_measure_cfg #(.INTEG_TICKS(IT), .EMIT_TICKS(ET), .PROX_MUX(PM),
      .VIS_MUX(VM), .EARLY_REV(1'b0)) u_dut (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc), .stb_i(stb),
      .we_i(we), .adr_i(adr), .sel_i(bsel), .dat_i(wdat), .dat_o(rdat),
      .ack_o(ack), .adc_sel_o(sel_w), .integrate_o(integ_w),
      .emitter_o(emit_w), .high_range_o(hr_w), .raw_mode_o(raw_w),
      .busy_o(busy_w), .done_o(done_w));
   scd_host_model u_host (
      .clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
      .we_o(we), .adr_o(adr), .sel_o(bsel), .dat_o(wdat));
   // 40 MHz clock
   always #12.5 clk_i = ~clk_i;
   // hang guard, far above the few thousand cycles the run needs
   always @(posedge clk_i) begin
      tick_n <= tick_n + 1;
      if (tick_n == 20000) begin
         end_sim(1'b1);
      end
   end
   // ********************************************************
   // helpers
   // ********************************************************
   function automatic logic [7:0] ba(input logic [5:0] i);
      return {i, 2'b00};
   endfunction
   task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic cmpn(input int g, input int e);
      checks++;
      if (g != e) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic end_sim(input bit tmo);
      if (tmo) n_fail++;
      if (n_fail == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // start one measurement, count delay and window lengths until idle
   task automatic meas(input logic [1:0] k, output int d, output int n,
      output int e);
      int dn;
      d = 0;
      dn = 0;
      n = 0;
      e = 0;
      u_host.wr(ba(CTRL_IDX), {5'h00, k, 1'b1}, 4'h1);
      do begin
         @(posedge clk_i);
         if (integ_w === 1'b1) n++;
         else if (n == 0) d++;
         if (emit_w === 1'b1) e++;
         if (done_w === 1'b1) dn++;
      end while (busy_w === 1'b1);
      cmpn(dn, 1);
   endtask
   // ********************************************************
   // scenarios
   // ********************************************************
   logic [5:0] ix [6] = '{PROX_GAIN_IDX, PROX_MISC_IDX, IR_SEL_IDX,
      AUX_SEL_IDX, VIS_REC_IDX, VIS_GAIN_IDX};
   logic [7:0] rv [6] = '{8'h00, 8'h04, 8'h00, 8'h65, 8'h70, 8'h00};
   logic [7:0] wv [6] = '{8'h05, 8'h24, 8'h03, 8'h75, 8'h60, 8'h01};
   task automatic t_reset;
      logic [7:0] q;
      for (int i = 0; i < 6; i++) begin
         u_host.rd(ba(ix[i]), q);
         cmp8(q, rv[i]);
      end
      u_host.rd(8'hfc, q);
      cmp8(q, 8'h00);
   endtask
   // gain 5 at most, recovery 6 is the complement of gain 1
   task automatic t_regs;
      logic [7:0] q;
      for (int i = 0; i < 6; i++) u_host.wr(ba(ix[i]), wv[i], 4'h1);
      u_host.wr(ba(AUX_SEL_IDX), 8'h65, 4'h0);
      u_host.wr(8'hfc, 8'h11, 4'h1);
      for (int i = 0; i < 6; i++) begin
         u_host.rd(ba(ix[i]), q);
         cmp8(q, wv[i]);
      end
      u_host.rd(8'hfc, q);
      cmp8(q, 8'h00);
   endtask
   task automatic t_prox;
      int d, n, e;
      logic [7:0] q;
      u_host.wr(ba(PROX_GAIN_IDX), 8'h00, 4'h1);
      u_host.wr(ba(PROX_MISC_IDX), 8'h04, 4'h1);
      meas(K_PROX, dprox, n, e);
      cmpn(n, IT * ADC_BASE_CYCLES);
      cmpn(e, ET * ADC_BASE_CYCLES);
      cmp8(sel_w, PM);
      cmp8({6'h00, hr_w, raw_w}, 8'h00);
      cmpn(dprox, 0);
      u_host.wr(ba(PROX_GAIN_IDX), 8'h02, 4'h1);
      meas(K_PROX, d, n, e);
      cmpn(n, IT * ADC_BASE_CYCLES * 4);
      cmpn(e, ET * ADC_BASE_CYCLES * 4);
      u_host.wr(ba(PROX_GAIN_IDX), 8'h04, 4'h1);
      u_host.wr(ba(PROX_MISC_IDX), 8'h20, 4'h1);
      meas(K_PROX, d, n, e);
      cmpn(d, 0);
      cmpn(n, IT * ADC_BASE_CYCLES * 16);
      cmpn(e, 0);
      cmp8({6'h00, hr_w, raw_w}, 8'h03);
      u_host.rd(ba(STAT_IDX), q);
      cmp8(q, 8'h08);
   endtask
   task automatic t_vis;
      int d0, d1, n, e;
      u_host.wr(ba(VIS_GAIN_IDX), 8'h00, 4'h1);
      u_host.wr(ba(VIS_REC_IDX), 8'h00, 4'h1);
      meas(K_VIS, d0, n, e);
      u_host.wr(ba(VIS_REC_IDX), 8'h70, 4'h1);
      meas(K_VIS, d1, n, e);
      cmpn(d1 - d0, 510 * ADC_BASE_CYCLES);
      cmpn(n, IT * ADC_BASE_CYCLES);
      cmp8(sel_w, VM);
      u_host.wr(ba(VIS_GAIN_IDX), 8'h01, 4'h1);
      u_host.wr(ba(VIS_REC_IDX), 8'h60, 4'h1);
      meas(K_VIS, d1, n, e);
      cmpn(n, IT * ADC_BASE_CYCLES * 2);
      cmpn(d1 - d0, 509 * ADC_BASE_CYCLES);
   endtask
   // recovery left at code 7: ambient ir must not wait for it here
   task automatic t_ir_aux;
      int d, n, e;
      logic [7:0] ic [2] = '{IR_SMALL_PD, IR_LARGE_PD};
      logic [7:0] ac [2] = '{AUX_TEMP, AUX_SUPPLY};
      u_host.wr(ba(VIS_REC_IDX), 8'h70, 4'h1);
      for (int i = 0; i < 2; i++) begin
         u_host.wr(ba(IR_SEL_IDX), ic[i], 4'h1);
         meas(K_IR, d, n, e);
         cmp8(sel_w, ic[i]);
         cmpn(d, 0);
         u_host.wr(ba(AUX_SEL_IDX), ac[i], 4'h1);
         meas(K_AUX, d, n, e);
         cmp8(sel_w, ac[i]);
      end
   endtask
   // main sequence
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_regs();
      t_prox();
      t_vis();
      t_ir_aux();
      end_sim(1'b0);
   end
endmodule
